// ### include/scsp_pkg.sv
package scsp_pkg;
	// ------------------------------------------------------------
	// register space
	// ------------------------------------------------------------
	localparam int AW = 8;
	localparam int DW = 8;
	localparam int REG_COUNT = 198;
	localparam logic [7:0] LAST_REG = 8'hC5;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] REG_RESET_VALUE = 8'h00;
	localparam logic [7:0] READ_FILL = 8'h00;
	// ------------------------------------------------------------
	// strap codes, addresses and commands
	// ------------------------------------------------------------
	localparam logic [1:0] STRAP_RESET = 2'h0;
	localparam logic [1:0] STRAP_TWO_WIRE = 2'h1;
	localparam logic [1:0] STRAP_FOUR_WIRE = 2'h2;
	localparam logic [7:0] TW_DEV_READ = 8'hBF;
	localparam logic [7:0] TW_DEV_WRITE = 8'hBE;
	localparam logic [7:0] SPI_CMD_READ = 8'h03;
	localparam logic [7:0] SPI_CMD_WRITE = 8'h02;
	// ------------------------------------------------------------
	// bit counting
	// ------------------------------------------------------------
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	// ------------------------------------------------------------
	// state types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SPI_CMD = 4'b0001,
		SPI_ADDR = 4'b0010,
		SPI_DATA = 4'b0100,
		SPI_HOLD = 4'b1000
	} scsp_spi_state_t;
	typedef enum logic [4:0] {
		TW_IDLE = 5'b00001,
		TW_DEV = 5'b00010,
		TW_REG = 5'b00100,
		TW_WR = 5'b01000,
		TW_RD = 5'b10000
	} scsp_tw_state_t;
endpackage : scsp_pkg

// ### rtl/scsp_top.sv
`timescale 1ns/1ps
module scsp_top (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic [1:0] PORT_SELECT_STRAP_IN,
	input wire logic SERIAL_SELECT_N_IN,
	input wire logic SERIAL_CLOCK_IN,
	input wire logic SERIAL_DATA_IN,
	output logic SERIAL_DATA_OUT,
	input wire logic TW_SCL_IN,
	input wire logic TW_SDA_IN,
	output logic TW_SDA_OUT,
	output logic TW_SDA_OE_OUT,
	output logic REG_WR_OUT,
	output logic [scsp_pkg::AW-1:0] REG_ADDR_OUT,
	output logic [scsp_pkg::DW-1:0] REG_WDATA_OUT,
	output logic MODE_TWO_WIRE_OUT,
	output logic MODE_FOUR_WIRE_OUT
);
	import scsp_pkg::*;

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [1:0] ss_sync;
	logic [1:0] sck_sync;
	logic [1:0] sdi_sync;
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [1:0] strap_s0;
	logic [1:0] strap_s1;
	logic sck_d;
	logic scl_d;
	logic sda_d;

	always_ff @(posedge CLK_IN) begin
		ss_sync <= {ss_sync[0], SERIAL_SELECT_N_IN};
		sck_sync <= {sck_sync[0], SERIAL_CLOCK_IN};
		sdi_sync <= {sdi_sync[0], SERIAL_DATA_IN};
		scl_sync <= {scl_sync[0], TW_SCL_IN};
		sda_sync <= {sda_sync[0], TW_SDA_IN};
		strap_s0 <= PORT_SELECT_STRAP_IN;
		strap_s1 <= strap_s0;
		sck_d <= sck_sync[1];
		scl_d <= scl_sync[1];
		sda_d <= sda_sync[1];
	end

	logic ss_n;
	logic sck_rise;
	logic sck_fall;
	logic scl_rise;
	logic scl_fall;
	logic tw_start;
	logic tw_stop;
	assign ss_n = ss_sync[1];
	assign sck_rise = sck_sync[1] & ~sck_d;
	assign sck_fall = ~sck_sync[1] & sck_d;
	assign scl_rise = scl_sync[1] & ~scl_d;
	assign scl_fall = ~scl_sync[1] & scl_d;
	assign tw_start = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
	assign tw_stop = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	// strap is followed while reset is high, frozen at release
	logic [1:0] mode;
	logic [1:0] next_mode;
	logic mode_tw;
	logic mode_fw;

	always_comb begin
		next_mode = mode;
		if (SRST_IN) begin
			next_mode = strap_s1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		mode <= next_mode;
	end

	assign mode_tw = (mode == STRAP_TWO_WIRE);
	assign mode_fw = (mode == STRAP_FOUR_WIRE);

	// ------------------------------------------------------------
	// register array
	// ------------------------------------------------------------
	logic [7:0] mem [0:REG_COUNT-1];
	logic [7:0] addr;
	logic [7:0] rd_data;
	logic [7:0] addr_inc;
	logic mem_we;
	logic [7:0] mem_wdata;

	// out-of-range start addresses read as fill and drop writes
	assign rd_data = (addr <= LAST_REG) ? mem[addr] : READ_FILL;
	assign addr_inc = (addr >= LAST_REG) ? ADDR_RESET : addr + 8'h01;

	// ------------------------------------------------------------
	// link state machines
	// ------------------------------------------------------------
	scsp_spi_state_t spi_state;
	scsp_spi_state_t next_spi_state;
	scsp_tw_state_t tw_state;
	scsp_tw_state_t next_tw_state;
	logic [3:0] bcnt;
	logic [3:0] next_bcnt;
	logic [7:0] shift;
	logic [7:0] next_shift;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic [7:0] next_addr;
	logic is_read;
	logic next_is_read;
	logic sdo;
	logic next_sdo;
	logic sda_low;
	logic next_sda_low;
	logic ack;
	logic next_ack;
	logic [7:0] byte_fw;
	logic [7:0] byte_tw;

	assign byte_fw = {shift[6:0], sdi_sync[1]};
	assign byte_tw = {shift[6:0], sda_sync[1]};

	always_comb begin
		next_spi_state = spi_state;
		next_tw_state = tw_state;
		next_bcnt = bcnt;
		next_shift = shift;
		next_tx = tx;
		next_addr = addr;
		next_is_read = is_read;
		next_sdo = sdo;
		next_sda_low = sda_low;
		next_ack = ack;
		mem_we = 1'b0;
		mem_wdata = byte_fw;
		if (mode_fw) begin
			if (ss_n) begin
				next_spi_state = SPI_CMD;
				next_bcnt = BIT_FIRST;
				next_sdo = 1'b0;
			end else if (sck_rise) begin
				next_shift = byte_fw;
				next_bcnt = bcnt + 4'h1;
				if (bcnt == BIT_LAST) begin
					next_bcnt = BIT_FIRST;
					case (spi_state)
						SPI_CMD: begin
							next_is_read = (byte_fw == SPI_CMD_READ);
							if (byte_fw == SPI_CMD_READ ||
									byte_fw == SPI_CMD_WRITE) begin
								next_spi_state = SPI_ADDR;
							end else begin
								next_spi_state = SPI_HOLD;
							end
						end
						SPI_ADDR: begin
							next_addr = byte_fw;
							next_spi_state = SPI_DATA;
						end
						SPI_DATA: begin
							mem_we = ~is_read;
							next_addr = addr_inc;
						end
						SPI_HOLD: begin
							next_spi_state = SPI_HOLD;
						end
						default: begin
							next_spi_state = SPI_HOLD;
						end
					endcase
				end
			end else if (sck_fall) begin
				if (spi_state == SPI_DATA && is_read) begin
					if (bcnt == BIT_FIRST) begin
						next_sdo = rd_data[7];
						next_tx = {rd_data[6:0], 1'b0};
					end else begin
						next_sdo = tx[7];
						next_tx = {tx[6:0], 1'b0};
					end
				end else begin
					next_sdo = 1'b0;
				end
			end
		end
		if (mode_tw) begin
			mem_wdata = byte_tw;
			if (tw_start) begin
				next_tw_state = TW_DEV;
				next_bcnt = BIT_FIRST;
				next_sda_low = 1'b0;
			end else if (tw_stop || tw_state == TW_IDLE) begin
				next_tw_state = TW_IDLE;
				next_sda_low = 1'b0;
			end else if (scl_rise) begin
				if (bcnt == BIT_ACK) begin
					next_bcnt = BIT_FIRST;
					// released line on the ack clock is a nack
					if (tw_state == TW_RD && sda_sync[1]) begin
						next_tw_state = TW_IDLE;
					end
				end else begin
					next_shift = byte_tw;
					next_bcnt = bcnt + 4'h1;
					if (bcnt == BIT_LAST) begin
						next_ack = 1'b1;
						case (tw_state)
							TW_DEV: begin
								if (byte_tw == TW_DEV_WRITE) begin
									next_tw_state = TW_REG;
								end else if (byte_tw == TW_DEV_READ) begin
									next_tw_state = TW_RD;
								end else begin
									next_tw_state = TW_IDLE;
									next_ack = 1'b0;
								end
							end
							TW_REG: begin
								next_addr = byte_tw;
								next_tw_state = TW_WR;
							end
							TW_WR: begin
								mem_we = 1'b1;
								next_addr = addr_inc;
							end
							TW_RD: begin
								next_ack = 1'b0;
							end
							default: begin
								next_tw_state = TW_IDLE;
								next_ack = 1'b0;
							end
						endcase
					end
				end
			end else if (scl_fall) begin
				if (bcnt == BIT_ACK) begin
					next_sda_low = ack;
				end else if (tw_state == TW_RD) begin
					if (bcnt == BIT_FIRST) begin
						next_sda_low = ~rd_data[7];
						next_tx = {rd_data[6:0], 1'b0};
						next_addr = addr_inc;
					end else begin
						next_sda_low = ~tx[7];
						next_tx = {tx[6:0], 1'b0};
					end
				end else begin
					next_sda_low = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			spi_state <= SPI_CMD;
			tw_state <= TW_IDLE;
			bcnt <= BIT_FIRST;
			shift <= REG_RESET_VALUE;
			tx <= REG_RESET_VALUE;
			addr <= ADDR_RESET;
			is_read <= 1'b0;
			sdo <= 1'b0;
			sda_low <= 1'b0;
			ack <= 1'b0;
		end else begin
			spi_state <= next_spi_state;
			tw_state <= next_tw_state;
			bcnt <= next_bcnt;
			shift <= next_shift;
			tx <= next_tx;
			addr <= next_addr;
			is_read <= next_is_read;
			sdo <= next_sdo;
			sda_low <= next_sda_low;
			ack <= next_ack;
		end
	end

	// ------------------------------------------------------------
	// register storage and write strobe
	// ------------------------------------------------------------
	// strobe lets the switch core apply a setting while running
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				mem[i] <= REG_RESET_VALUE;
			end
			REG_WR_OUT <= 1'b0;
			REG_ADDR_OUT <= ADDR_RESET;
			REG_WDATA_OUT <= REG_RESET_VALUE;
		end else begin
			if (mem_we && addr <= LAST_REG) begin
				mem[addr] <= mem_wdata;
			end
			REG_WR_OUT <= mem_we && (addr <= LAST_REG);
			if (mem_we) begin
				REG_ADDR_OUT <= addr;
				REG_WDATA_OUT <= mem_wdata;
			end
		end
	end

	assign SERIAL_DATA_OUT = sdo;
	assign TW_SDA_OUT = 1'b0;
	assign TW_SDA_OE_OUT = sda_low;
	assign MODE_TWO_WIRE_OUT = mode_tw;
	assign MODE_FOUR_WIRE_OUT = mode_fw;
endmodule : scsp_top

// ### testbench/scsp_top_sva.sv
`timescale 1ns/1ps
module scsp_top_sva (
	input wire logic CLK_IN,
	input wire logic SRST_IN,
	input wire logic [1:0] PORT_SELECT_STRAP_IN,
	input wire logic SERIAL_SELECT_N_IN,
	input wire logic SERIAL_CLOCK_IN,
	input wire logic SERIAL_DATA_OUT,
	input wire logic TW_SDA_OE_OUT,
	input wire logic REG_WR_OUT,
	input wire logic [scsp_pkg::AW-1:0] REG_ADDR_OUT,
	input wire logic MODE_TWO_WIRE_OUT,
	input wire logic MODE_FOUR_WIRE_OUT
);
	import scsp_pkg::*;
	// ----
	// checks
	// ----
	logic [1:0] mode;
	logic [1:0] want;
	assign mode = {MODE_TWO_WIRE_OUT, MODE_FOUR_WIRE_OUT};
	assign want = {PORT_SELECT_STRAP_IN == STRAP_TWO_WIRE,
		PORT_SELECT_STRAP_IN == STRAP_FOUR_WIRE};
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);
	a_mode_strap:
		assert property ($fell(SRST_IN) |-> mode == $past(want, 4))
		else $error("mode differs from strap");
	// strap is only caught at reset, never while running
	a_mode_hold:
		assert property ($stable(mode)) else $error("mode moved");
	a_wr_gap:
		assert property (REG_WR_OUT |=> !REG_WR_OUT [*8])
		else $error("write strobe too close");
	a_wr_range:
		assert property (REG_WR_OUT |-> REG_ADDR_OUT <= LAST_REG)
		else $error("write beyond last register");
	a_wr_mode:
		assert property (REG_WR_OUT |-> mode != 2'h0)
		else $error("write with no slave");
	a_sdo_launch:
		assert property ($changed(SERIAL_DATA_OUT) |-> !SERIAL_CLOCK_IN)
		else $error("data out moved in clock high");
	a_sdo_idle:
		assert property (SERIAL_SELECT_N_IN [*5] |-> !SERIAL_DATA_OUT)
		else $error("data out driven while deselected");
	a_tw_quiet:
		assert property (MODE_FOUR_WIRE_OUT |-> !TW_SDA_OE_OUT)
		else $error("two-wire pull in four-wire mode");
	a_four_quiet:
		assert property (MODE_TWO_WIRE_OUT |-> !SERIAL_DATA_OUT)
		else $error("four-wire out in two-wire mode");
	a_oe_mode:
		assert property (TW_SDA_OE_OUT |-> MODE_TWO_WIRE_OUT)
		else $error("two-wire pull with no two-wire mode");
endmodule : scsp_top_sva
bind scsp_top scsp_top_sva i_scsp_top_sva (.CLK_IN(CLK_IN),
	.SRST_IN(SRST_IN), .PORT_SELECT_STRAP_IN(PORT_SELECT_STRAP_IN),
	.SERIAL_SELECT_N_IN(SERIAL_SELECT_N_IN),
	.SERIAL_CLOCK_IN(SERIAL_CLOCK_IN), .SERIAL_DATA_OUT(SERIAL_DATA_OUT),
	.TW_SDA_OE_OUT(TW_SDA_OE_OUT), .REG_WR_OUT(REG_WR_OUT),
	.REG_ADDR_OUT(REG_ADDR_OUT), .MODE_TWO_WIRE_OUT(MODE_TWO_WIRE_OUT),
	.MODE_FOUR_WIRE_OUT(MODE_FOUR_WIRE_OUT));

// ### testbench/scsp_spi_master.sv
`timescale 1ns/1ps
module scsp_spi_master (
	input wire logic clk_in,
	input wire logic miso_in,
	output logic sel_n_out,
	output logic sclk_out,
	output logic mosi_out
);
	// ----
	// master
	// ----
	initial begin
		sel_n_out = 1'h1;
		sclk_out = 1'h0;
		mosi_out = 1'h0;
	end
	task automatic half();
		repeat (4) @(posedge clk_in);
	endtask : half
	task automatic open_f();
		@(posedge clk_in);
		sel_n_out <= 1'h0;
		half();
	endtask : open_f
	// sampled late in the high phase: output stands till next fall
	task automatic xfer(input logic [7:0] tx, input int nb,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i >= 8 - nb; i--) begin
			mosi_out <= tx[i];
			half();
			sclk_out <= 1'h1;
			half();
			rx[i] = miso_in;
			sclk_out <= 1'h0;
		end
	endtask : xfer
	// released data line shows the inverse, not a stale bit
	task automatic close_f();
		half();
		sel_n_out <= 1'h1;
		mosi_out <= ~mosi_out;
		repeat (4) @(posedge clk_in);
	endtask : close_f
endmodule : scsp_spi_master

module scsp_tw_master (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	// ----
	// two-wire master
	// ----
	// an output at 1 only releases the wire; the bench adds the pull-up
	initial begin
		scl_out = 1'h1;
		sda_out = 1'h1;
	end
	task automatic half();
		repeat (4) @(posedge clk_in);
	endtask : half
	// data moves only in the low phase, clear of the slave's own drive
	task automatic bit_c(input logic b, output logic r);
		half();
		sda_out <= b;
		half();
		scl_out <= 1'h1;
		half();
		r = sda_in;
		scl_out <= 1'h0;
	endtask : bit_c
	// also serves as a repeated start from the low phase
	task automatic start_c();
		half();
		sda_out <= 1'h1;
		half();
		scl_out <= 1'h1;
		half();
		sda_out <= 1'h0;
		half();
		scl_out <= 1'h0;
	endtask : start_c
	task automatic stop_c();
		half();
		sda_out <= 1'h0;
		half();
		scl_out <= 1'h1;
		half();
		sda_out <= 1'h1;
		half();
	endtask : stop_c
	task automatic byte_c(input logic [7:0] tx, input logic ak,
		output logic [7:0] rx, output logic ar);
		logic r;
		rx = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			bit_c(tx[i], r);
			rx[i] = r;
		end
		bit_c(ak, ar);
	endtask : byte_c
endmodule : scsp_tw_master

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import scsp_pkg::*;
	logic CLK_IN;
	logic SRST_IN;
	logic [1:0] strap;
	logic sel_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic wr;
	logic [7:0] wa;
	logic [7:0] wd;
	logic m2;
	logic m4;
	logic scl;
	logic msda;
	logic sda_w;
	logic tsda;
	logic oe;
	logic [7:0] tr;
	logic ta;
	logic [7:0] tx [4];
	logic [7:0] rx [4];
	logic [15:0] wq [$];
	int bad_count = 0;
	int compares = 0;
	scsp_spi_master i_scsp_spi_master (.clk_in(CLK_IN), .miso_in(miso),
		.sel_n_out(sel_n), .sclk_out(sclk), .mosi_out(mosi));
	scsp_tw_master i_scsp_tw_master (.clk_in(CLK_IN), .sda_in(sda_w),
		.scl_out(scl), .sda_out(msda));
	// released wire rests high through its pull-up
	assign sda_w = oe ? (tsda & msda) : msda;
	scsp_top i_scsp_top (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
		.PORT_SELECT_STRAP_IN(strap), .SERIAL_SELECT_N_IN(sel_n),
		.SERIAL_CLOCK_IN(sclk), .SERIAL_DATA_IN(mosi),
		.SERIAL_DATA_OUT(miso), .TW_SCL_IN(scl), .TW_SDA_IN(sda_w),
		.TW_SDA_OUT(tsda), .TW_SDA_OE_OUT(oe), .REG_WR_OUT(wr),
		.REG_ADDR_OUT(wa), .REG_WDATA_OUT(wd),
		.MODE_TWO_WIRE_OUT(m2), .MODE_FOUR_WIRE_OUT(m4));
	initial begin
		CLK_IN = 1'h0;
		forever #20 CLK_IN = ~CLK_IN;
	end
	always @(posedge CLK_IN) begin
		if (wr === 1'h1)
			wq.push_back({wa, wd});
	end
	// ----
	// tasks
	// ----
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report();
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report
	task automatic rst(input logic [1:0] s);
		@(posedge CLK_IN);
		SRST_IN <= 1'h1;
		strap <= s;
		repeat (16) @(posedge CLK_IN);
		SRST_IN <= 1'h0;
		repeat (4) @(posedge CLK_IN);
	endtask : rst
	task automatic twb(input logic [7:0] b, input logic ak);
		i_scsp_tw_master.byte_c(b, ak, tr, ta);
	endtask : twb
	task automatic frame(input logic [7:0] cmd, input logic [7:0] adr,
		input int n, input int nb);
		logic [7:0] r;
		i_scsp_spi_master.open_f();
		i_scsp_spi_master.xfer(cmd, 8, r);
		i_scsp_spi_master.xfer(adr, 8, r);
		for (int i = 0; i < n; i++) begin
			i_scsp_spi_master.xfer(tx[i], nb, r);
			rx[i] = r;
		end
		i_scsp_spi_master.close_f();
	endtask : frame
	// ----
	// tests
	// ----
	initial begin
		SRST_IN = 1'h1;
		strap = 2'h0;
		for (int s = 0; s < 4; s++) begin
			rst(2'(s));
			chk(16'({m2, m4}), 16'({s == 1, s == 2}));
		end
		$display("test modes done");
		rst(STRAP_FOUR_WIRE);
		tx = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
		frame(SPI_CMD_WRITE, LAST_REG - 8'h01, 4, 8);
		chk(16'(wq.size()), 16'h0004);
		for (int i = 0; i < 4; i++) begin
			chk(wq[i], {8'((REG_COUNT - 2 + i) % REG_COUNT), tx[i]});
		end
		$display("test burst write done");
		wq.delete();
		frame(SPI_CMD_READ, LAST_REG - 8'h01, 4, 8);
		for (int i = 0; i < 4; i++) begin
			chk(16'(rx[i]), 16'(tx[i]));
		end
		chk(16'(wq.size()), 16'h0000);
		$display("test burst read done");
		// odd command, then a write cut short mid-byte
		frame(8'h0B, 8'h00, 1, 8);
		frame(SPI_CMD_WRITE, 8'h00, 1, 4);
		chk(16'(wq.size()), 16'h0000);
		frame(SPI_CMD_READ, 8'h00, 1, 8);
		chk(16'(rx[0]), 16'h0081);
		$display("test refusals done");
		// two-wire: write across the wrap, read back, foreign address
		rst(STRAP_TWO_WIRE);
		i_scsp_tw_master.start_c();
		twb(TW_DEV_WRITE, 1'h1);
		chk(16'(ta), 16'h0000);
		twb(LAST_REG, 1'h1);
		twb(8'h5A, 1'h1);
		twb(8'hC3, 1'h1);
		chk(16'(ta), 16'h0000);
		i_scsp_tw_master.stop_c();
		chk(16'(wq.size()), 16'h0002);
		chk(wq[0], {LAST_REG, 8'h5A});
		chk(wq[1], 16'h00C3);
		i_scsp_tw_master.start_c();
		twb(TW_DEV_WRITE, 1'h1);
		twb(LAST_REG, 1'h1);
		i_scsp_tw_master.start_c();
		twb(TW_DEV_READ, 1'h1);
		chk(16'(ta), 16'h0000);
		twb(8'hFF, 1'h0);
		chk(16'(tr), 16'h005A);
		twb(8'hFF, 1'h1);
		chk(16'(tr), 16'h00C3);
		i_scsp_tw_master.stop_c();
		i_scsp_tw_master.start_c();
		twb(8'hA0, 1'h1);
		chk(16'(ta), 16'h0001);
		i_scsp_tw_master.stop_c();
		chk(16'(wq.size()), 16'h0002);
		$display("test two-wire done");
		rst(STRAP_FOUR_WIRE);
		frame(SPI_CMD_READ, LAST_REG, 1, 8);
		chk(16'(rx[0]), 16'(REG_RESET_VALUE));
		$display("test reset clear done");
		final_report();
	end
endmodule : testbench
